//--- design/cmt_top.sv
// Channel minimum tracker bank with AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module cmt_top
   import cmt_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Conversion results from the converter datapath, same clock
   input wire logic res_valid_i,
   input wire logic [1:0] res_ch_i,
   input wire logic [CMT_CODE_W-1:0] res_code_i,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [CMT_ADDR_W-1:0] s_axi_awaddr_i,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   // AXI4-Lite write response
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [CMT_ADDR_W-1:0] s_axi_araddr_i,
   // AXI4-Lite read data
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o
);
   cmt_rd_if rd_bus ();

   logic aw_got_ff, nxt_aw_got;
   logic w_got_ff, nxt_w_got;
   logic [CMT_ADDR_W-1:0] awaddr_ff, nxt_awaddr;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic awready_ff, nxt_awready;
   logic wready_ff, nxt_wready;
   logic arready_ff, nxt_arready;
   logic rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic rd_hit;
   logic ar_take;

   assign s_axi_awready_o = awready_ff;
   assign s_axi_wready_o = wready_ff;
   assign s_axi_bvalid_o = bvalid_ff;
   assign s_axi_bresp_o = bresp_ff;
   assign s_axi_arready_o = arready_ff;
   assign s_axi_rvalid_o = rvalid_ff;
   assign s_axi_rdata_o = rdata_ff;
   assign s_axi_rresp_o = rresp_ff;

   // Word address index 0x88..0x8f maps to byte addresses 0x220..0x23c
   function automatic logic map_hit(input logic [CMT_ADDR_W-1:0] a);
      logic [CMT_ADDR_W-1:0] base;
      base = {2'b00, CMT_BASE_OFS, 2'b00};
      return (a[CMT_ADDR_W-1:5] == base[CMT_ADDR_W-1:5]) && (a[1:0] == 2'b00);
   endfunction : map_hit

   // Write channel: registers are read-only, so writes only get an answer
   always_comb begin
      nxt_aw_got = aw_got_ff;
      nxt_w_got = w_got_ff;
      nxt_awaddr = awaddr_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      if (s_axi_awvalid_i && awready_ff) begin
         nxt_aw_got = 1'b1;
         nxt_awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_ff) begin
         nxt_w_got = 1'b1;
      end
      if (bvalid_ff && s_axi_bready_i) begin
         nxt_bvalid = 1'b0;
      end
      if (nxt_aw_got && nxt_w_got && !bvalid_ff) begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bvalid = 1'b1;
         // Data never reaches the trackers; mapped writes draw SLVERR
         nxt_bresp = map_hit(nxt_awaddr) ? CMT_RESP_SLVERR : CMT_RESP_DECERR;
      end
      nxt_awready = !nxt_aw_got && !nxt_bvalid;
      nxt_wready = !nxt_w_got && !nxt_bvalid;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= CMT_RESP_OKAY;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
      end else begin
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         awaddr_ff <= nxt_awaddr;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
      end
   end

   // Read channel: the read itself clears the addressed tracker pair
   always_comb begin
      ar_take = s_axi_arvalid_i && arready_ff;
      rd_hit = map_hit(s_axi_araddr_i);
      rd_bus.rd_idx = s_axi_araddr_i[4:2];
      rd_bus.rd_en = ar_take && rd_hit;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (rvalid_ff && s_axi_rready_i) begin
         nxt_rvalid = 1'b0;
      end
      if (ar_take) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = rd_hit ? {24'h00_0000, rd_bus.rd_byte} : CMT_RDATA_RESET;
         nxt_rresp = rd_hit ? CMT_RESP_OKAY : CMT_RESP_DECERR;
      end
      nxt_arready = !nxt_rvalid && !ar_take;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= CMT_RDATA_RESET;
         rresp_ff <= CMT_RESP_OKAY;
         arready_ff <= 1'b0;
      end else begin
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
         arready_ff <= nxt_arready;
      end
   end

   cmt_track_bank #(
      .NUM_CH(CMT_NUM_CH),
      .CODE_W(CMT_CODE_W)
   ) u_bank (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .res_valid_i(res_valid_i),
      .res_ch_i(res_ch_i),
      .res_code_i(res_code_i),
      .rd(rd_bus.bank)
   );
endmodule : cmt_top

//--- design/cmt_track_bank.sv
// Per-channel lowest code trackers with read-and-rearm
`timescale 1ns/1ps
module cmt_track_bank
   import cmt_pkg::*;
#(
   parameter int NUM_CH = CMT_NUM_CH,
   parameter int CODE_W = CMT_CODE_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Conversion results
   input wire logic res_valid_i,
   input wire logic [1:0] res_ch_i,
   input wire logic [CODE_W-1:0] res_code_i,
   // Read side
   cmt_rd_if.bank rd
);
   logic [CODE_W-1:0] min_ff [NUM_CH];
   logic [CODE_W-1:0] nxt_min [NUM_CH];

   // Combinational read byte; the bus slave latches it in the same cycle as rd_en
   always_comb begin
      rd.rd_byte = min_ff[rd.rd_idx[2:1]][8*rd.rd_idx[0] +: 8];
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic hit_rd;
         logic hit_res;
         always_comb begin
            hit_rd = rd.rd_en && (rd.rd_idx[2:1] == 2'(g));
            hit_res = res_valid_i && (res_ch_i == 2'(g));
            nxt_min[g] = min_ff[g];
            // Rearm covers the whole pair; a result in the same cycle then seeds it
            if (hit_rd) begin
               nxt_min[g] = CMT_MIN_RESET;
            end
            if (hit_res && (res_code_i < nxt_min[g])) begin
               nxt_min[g] = res_code_i;
            end
         end
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               min_ff[g] <= CMT_MIN_RESET;
            end else begin
               min_ff[g] <= nxt_min[g];
            end
         end
      end
   endgenerate
endmodule : cmt_track_bank

//--- shared/cmt_pkg.sv
// Constants and types for the channel minimum tracker bank
// Summary of operation
// - Keep lowest code per channel since read
// - Read returns minimum, then rearms to ones
// - Reset leaves every minimum register all ones
// - Low bytes even from 0x88, high odd
package cmt_pkg;
   localparam int CMT_NUM_CH = 4;
   localparam int CMT_FIRST_CH = 4;
   localparam int CMT_CODE_W = 16;
   localparam logic [7:0] CMT_BASE_OFS = 8'h88;
   localparam logic [7:0] CMT_CH4_LOW_OFS = 8'h88;
   localparam logic [7:0] CMT_CH4_HIGH_OFS = 8'h89;
   localparam logic [7:0] CMT_CH5_LOW_OFS = 8'h8a;
   localparam logic [7:0] CMT_CH5_HIGH_OFS = 8'h8b;
   localparam logic [7:0] CMT_CH6_LOW_OFS = 8'h8c;
   localparam logic [7:0] CMT_CH6_HIGH_OFS = 8'h8d;
   localparam logic [7:0] CMT_CH7_LOW_OFS = 8'h8e;
   localparam logic [7:0] CMT_CH7_HIGH_OFS = 8'h8f;
   localparam int CMT_ADDR_W = 12;
   localparam logic [7:0] CMT_BYTE_RESET = 8'hff;
   localparam logic [15:0] CMT_MIN_RESET = 16'hffff;
   localparam logic [1:0] CMT_RESP_OKAY = 2'b00;
   localparam logic [1:0] CMT_RESP_SLVERR = 2'b10;
   localparam logic [1:0] CMT_RESP_DECERR = 2'b11;
   localparam logic [31:0] CMT_RDATA_RESET = 32'h0000_0000;
endpackage : cmt_pkg

//--- shared/cmt_rd_if.sv
// Read-clear request carrier between the bus slave and the tracker bank
`timescale 1ns/1ps
interface cmt_rd_if;
   import cmt_pkg::*;
   logic rd_en;
   logic [2:0] rd_idx;
   logic [7:0] rd_byte;
   modport slave (output rd_en, output rd_idx, input rd_byte);
   modport bank (input rd_en, input rd_idx, output rd_byte);
endinterface : cmt_rd_if

//--- tb/cmt_top_sva.sv
// Bus checks for the minimum tracker bank
`timescale 1ns/1ps
module cmt_top_sva
   import cmt_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Watched bus signals
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic [1:0] s_axi_bresp_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence rd_take;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   sequence rd_wait;
      s_axi_rvalid_o && !s_axi_rready_i;
   endsequence
   rd_answer_a: assert property (rd_take |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read answer not one cycle after accept");
   rd_hold_a: assert property (rd_wait |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data moved before taken");
   rd_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   rd_unmapped_a: assert property (rd_take ##1 (s_axi_rresp_o == CMT_RESP_DECERR)
      |-> s_axi_rdata_o == 32'h0000_0000)
      else $error("unmapped read returned data");
   wr_refused_a: assert property (s_axi_bvalid_o |-> s_axi_bresp_o != CMT_RESP_OKAY)
      else $error("write answered okay");
endmodule : cmt_top_sva
bind cmt_top cmt_top_sva chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bresp_o(s_axi_bresp_o));

//--- tb/tb_top.sv
// Self-checking bench for the minimum tracker bank
`timescale 1ns/1ps
module tb_top;
   import cmt_pkg::*;
   logic clk_i, arst_n_i, res_valid_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
   logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0] res_ch_i, s_axi_bresp_o, s_axi_rresp_o;
   logic [15:0] res_code_i, m;
   logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i;
   int err_count, n_checks, c;
   cmt_top dut_u (.clk_i, .arst_n_i, .res_valid_i, .res_ch_i, .res_code_i, .s_axi_awvalid_i,
      .s_axi_awready_o, .s_axi_awaddr_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i,
      .s_axi_wstrb_i, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i,
      .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
      .s_axi_rresp_o);
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic tmo(input int n);
      chk("timeout", 32'h0000_0000, 32'(n >= 50));
      if (n >= 50) tally_and_finish();
   endtask : tmo
   function automatic logic [11:0] ad(input int ch, input int hi);
      return {2'b00, CMT_BASE_OFS, 2'b00} + 12'(8 * ch + 4 * hi);
   endfunction : ad
   // Ready stands with the request, so data are taken at the edge that shows them
   task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk_i);
      s_axi_arvalid_i <= 1'b1;
      s_axi_araddr_i <= a;
      s_axi_rready_i <= 1'b1;
      for (n = 0; n < 50 && s_axi_rvalid_o !== 1'b1; n++) begin
         @(posedge clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end
      tmo(n);
      chk("rdata", {24'h00_0000, ed}, s_axi_rdata_o);
      chk("rresp", 32'(er), 32'(s_axi_rresp_o));
      s_axi_rready_i <= 1'b0;
   endtask : rd
   task automatic wr(input logic [11:0] a, input logic [1:0] er);
      int n;
      @(posedge clk_i);
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_awaddr_i <= a;
      s_axi_bready_i <= 1'b1;
      for (n = 0; n < 50 && s_axi_bvalid_o !== 1'b1; n++) begin
         @(posedge clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end
      tmo(n);
      chk("bresp", 32'(er), 32'(s_axi_bresp_o));
      s_axi_bready_i <= 1'b0;
   endtask : wr
   task automatic res(input int ch, input logic [15:0] code);
      @(posedge clk_i);
      res_valid_i <= 1'b1;
      res_ch_i <= 2'(ch);
      res_code_i <= code;
      @(posedge clk_i);
      res_valid_i <= 1'b0;
   endtask : res
   initial begin
      err_count = 0;
      n_checks = 0;
      {arst_n_i, res_valid_i, res_ch_i, res_code_i} = '0;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_awaddr_i} = '0;
      {s_axi_arvalid_i, s_axi_rready_i, s_axi_araddr_i} = '0;
      s_axi_wdata_i = 32'h0000_0000;
      s_axi_wstrb_i = 4'hf;
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      for (c = 0; c < 4; c++) begin
         rd(ad(c, 1), 8'hff, CMT_RESP_OKAY);
         rd(ad(c, 0), 8'hff, CMT_RESP_OKAY);
      end
      for (c = 0; c < 4; c++) begin
         m = 16'h3a10 + 16'(c * 257);
         res(c, m + 16'h0001);
         res(c, m);
         res(c, 16'hffff);
         res(c, m + 16'h0100);
         wr(ad(c, 0), CMT_RESP_SLVERR);
         rd(ad(c, 1), m[15:8], CMT_RESP_OKAY);
         rd(ad(c, 0), 8'hff, CMT_RESP_OKAY);
         res(c, 16'(c));
         rd(ad(c, 0), 8'(c), CMT_RESP_OKAY);
         rd(ad(c, 1), 8'hff, CMT_RESP_OKAY);
      end
      wr(12'h300, CMT_RESP_DECERR);
      rd(12'h240, 8'h00, CMT_RESP_DECERR);
      tally_and_finish();
   end
endmodule : tb_top
